// *** pacf_filter.sv ***
// forwarding filter for port and address based network access control
//
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module pacf_filter
  import pacf_pkg::*;
(
  input  wire logic              CORE_CLK,
  input  wire logic              RESETN,
  input  wire logic [ADDR_W-1:0] REG_ADDR,
  input  wire logic [DATA_W-1:0] REG_WDATA,
  input  wire logic              REG_WR,
  input  wire logic              REG_RD,
  output logic      [DATA_W-1:0] REG_RDATA,
  input  wire pacf_frame_type    FRAME_IN,
  output pacf_verdict_type       VERDICT_OUT
);

  // ****************************************************************
  // configuration storage
  // ****************************************************************
  logic [NUM_PORTS-1:0] aggr_mask_reg  [NUM_AGGR];
  logic [NUM_PORTS-1:0] src_mask_reg   [NUM_PORTS];
  logic [RSV_COUNT-1:0] redir_cfg_reg  [NUM_PORTS];
  // learn cfg holds the enable, cpu copy, drop and auto bits
  localparam int unsigned LRN_CFG_W = LRN_AUTO_BIT + 1;
  logic [LRN_CFG_W-1:0] learn_cfg_reg  [NUM_PORTS];
  logic [QUEUE_W-1:0]   rsv_queue_reg  [RSV_COUNT];
  logic [DATA_W-1:0]    fwd_count_reg;
  logic [DATA_W-1:0]    cpu_count_reg;
  logic [DATA_W-1:0]    drop_count_reg;
  logic [DATA_W-1:0]    rdata_next;

  // true when addr falls in a table of n words starting at base
  function automatic logic in_table(input logic [ADDR_W-1:0] addr,
                                    input logic [ADDR_W-1:0] base,
                                    input int unsigned n);
    in_table = (addr >= base) && (32'(addr) < 32'(base) + n);
  endfunction : in_table

  function automatic logic [PORT_IDX_W-1:0] tbl_idx(input logic [ADDR_W-1:0] addr,
                                                    input logic [ADDR_W-1:0] base);
    logic [ADDR_W-1:0] diff;
    diff = addr - base;
    tbl_idx = diff[PORT_IDX_W-1:0];
  endfunction : tbl_idx

  // ****************************************************************
  // register address decode
  // ****************************************************************
  // table hits for the write side; the tables never overlap,
  // so at most one of them is high for any address
  logic hit_aggr;
  logic hit_src;
  logic hit_redir;
  logic hit_learn;
  logic hit_queue;

  assign hit_aggr  = in_table(REG_ADDR, OFS_AGGR_MASK, NUM_AGGR);
  assign hit_src   = in_table(REG_ADDR, OFS_SRC_MASK, NUM_PORTS);
  assign hit_redir = in_table(REG_ADDR, OFS_REDIR_CFG, NUM_PORTS);
  assign hit_learn = in_table(REG_ADDR, OFS_LEARN_CFG, NUM_PORTS);
  assign hit_queue = in_table(REG_ADDR, OFS_RSV_QUEUE, RSV_COUNT);

  // ****************************************************************
  // configuration writes
  // ****************************************************************
  // aggregation masks; a bit cleared in every entry shuts a port out
  always_ff @(posedge CORE_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      for (int i = 0; i < NUM_AGGR; i++)
        aggr_mask_reg[i] <= AGGR_MASK_RESET;
    end
    else if (REG_WR && hit_aggr)
    begin
      aggr_mask_reg[tbl_idx(REG_ADDR, OFS_AGGR_MASK)] <= REG_WDATA[NUM_PORTS-1:0];
    end
  end

  // source masks; all zeros keeps a port's frames at home
  always_ff @(posedge CORE_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      for (int i = 0; i < NUM_PORTS; i++)
        src_mask_reg[i] <= SRC_MASK_RESET;
    end
    else if (REG_WR && hit_src)
    begin
      src_mask_reg[tbl_idx(REG_ADDR, OFS_SRC_MASK)] <= REG_WDATA[NUM_PORTS-1:0];
    end
  end

  // reserved address redirect enables, one bit per reserved index
  always_ff @(posedge CORE_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      for (int i = 0; i < NUM_PORTS; i++)
        redir_cfg_reg[i] <= '0;
    end
    else if (REG_WR && hit_redir)
    begin
      redir_cfg_reg[tbl_idx(REG_ADDR, OFS_REDIR_CFG)] <= REG_WDATA[RSV_COUNT-1:0];
    end
  end

  // per port learn settings
  always_ff @(posedge CORE_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      for (int i = 0; i < NUM_PORTS; i++)
        learn_cfg_reg[i] <= '0;
    end
    else if (REG_WR && hit_learn)
    begin
      learn_cfg_reg[tbl_idx(REG_ADDR, OFS_LEARN_CFG)] <= REG_WDATA[LRN_CFG_W-1:0];
    end
  end

  // cpu queue per reserved index
  always_ff @(posedge CORE_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      for (int i = 0; i < RSV_COUNT; i++)
        rsv_queue_reg[i] <= '0;
    end
    else if (REG_WR && hit_queue)
    begin
      rsv_queue_reg[tbl_idx(REG_ADDR, OFS_RSV_QUEUE)] <= REG_WDATA[QUEUE_W-1:0];
    end
  end

  // ****************************************************************
  // frame decision
  // ****************************************************************
  logic [PORT_IDX_W-1:0] sp;
  logic                  port_ok;
  logic                  is_rsv;
  logic [RSV_IDX_W-1:0]  rsv_idx;
  logic                  redirect;
  logic                  lrn_ena;
  logic                  lrn_cpu;
  logic                  lrn_drop;
  logic                  lrn_auto;
  logic                  unknown;
  logic [NUM_PORTS-1:0]  fwd_set;
  pacf_verdict_type      verdict_next;

  assign sp       = FRAME_IN.src_port;
  assign port_ok  = 32'(sp) < NUM_PORTS;
  assign is_rsv   = FRAME_IN.dmac[47:4] == RSV_MAC_PREFIX;
  assign rsv_idx  = FRAME_IN.dmac[RSV_IDX_W-1:0];

  always_comb
  begin
    verdict_next = '0;
    redirect = 1'b0;
    lrn_ena  = 1'b0;
    lrn_cpu  = 1'b0;
    lrn_drop = 1'b0;
    lrn_auto = 1'b0;
    fwd_set  = '0;
    unknown  = 1'b0;
    if (FRAME_IN.valid && port_ok)
    begin
      verdict_next.valid = 1'b1;
      lrn_ena  = learn_cfg_reg[sp][LRN_ENA_BIT];
      lrn_cpu  = learn_cfg_reg[sp][LRN_CPU_BIT];
      lrn_drop = learn_cfg_reg[sp][LRN_DROP_BIT];
      lrn_auto = learn_cfg_reg[sp][LRN_AUTO_BIT];
      // reserved address redirect, checked before any mask
      redirect = is_rsv && redir_cfg_reg[sp][rsv_idx];
      unknown  = !FRAME_IN.smac_known;
      // final set through aggregation and source masks
      fwd_set = FRAME_IN.dest_set & aggr_mask_reg[FRAME_IN.aggr_code] & src_mask_reg[sp];
      if (redirect)
      begin
        verdict_next.to_cpu    = 1'b1;
        verdict_next.cpu_queue = rsv_queue_reg[rsv_idx];
      end
      else if (unknown && lrn_ena && !lrn_auto)
      begin
        // unknown source forwarded only if drop bit clear; copy to cpu only if enabled
        verdict_next.to_cpu    = lrn_cpu;
        verdict_next.learn_req = lrn_cpu;
        verdict_next.cpu_queue = rsv_queue_reg[AUTH_RSV_IDX];
        verdict_next.fwd_ports = lrn_drop ? '0 : fwd_set;
        verdict_next.dropped   = !lrn_cpu && lrn_drop;
      end
      else
      begin
        verdict_next.fwd_ports = fwd_set;
        verdict_next.learn_req = unknown && lrn_ena && lrn_auto;
        verdict_next.dropped   = (fwd_set == '0);
      end
    end
  end

  // ****************************************************************
  // verdict register
  // ****************************************************************
  // verdict stands for exactly one cycle after its frame
  always_ff @(posedge CORE_CLK or negedge RESETN)
  begin
    if (!RESETN)
      VERDICT_OUT <= '0;
    else
      VERDICT_OUT <= verdict_next;
  end

  // ****************************************************************
  // statistics
  // ****************************************************************
  // counters wrap silently; software reads them as running totals
  function automatic logic [DATA_W-1:0] bump(input logic [DATA_W-1:0] value);
    bump = value + 32'h0000_0001;
  endfunction : bump

  // frames that left for at least one port
  always_ff @(posedge CORE_CLK or negedge RESETN)
  begin
    if (!RESETN)
      fwd_count_reg <= '0;
    else if (verdict_next.valid && verdict_next.fwd_ports != '0)
      fwd_count_reg <= bump(fwd_count_reg);
  end

  // frames handed to the cpu, redirected or as learn copies
  always_ff @(posedge CORE_CLK or negedge RESETN)
  begin
    if (!RESETN)
      cpu_count_reg <= '0;
    else if (verdict_next.to_cpu)
      cpu_count_reg <= bump(cpu_count_reg);
  end

  // frames flagged dropped: empty forward set outside the redirect and learn paths, or learn drop bit set without cpu copy
  always_ff @(posedge CORE_CLK or negedge RESETN)
  begin
    if (!RESETN)
      drop_count_reg <= '0;
    else if (verdict_next.dropped)
      drop_count_reg <= bump(drop_count_reg);
  end

  // ****************************************************************
  // register read
  // ****************************************************************
  always_comb
  begin
    rdata_next = UNMAPPED_DATA;
    if (in_table(REG_ADDR, OFS_AGGR_MASK, NUM_AGGR))
      rdata_next = DATA_W'(aggr_mask_reg[tbl_idx(REG_ADDR, OFS_AGGR_MASK)]);
    else if (in_table(REG_ADDR, OFS_SRC_MASK, NUM_PORTS))
      rdata_next = DATA_W'(src_mask_reg[tbl_idx(REG_ADDR, OFS_SRC_MASK)]);
    else if (in_table(REG_ADDR, OFS_REDIR_CFG, NUM_PORTS))
      rdata_next = DATA_W'(redir_cfg_reg[tbl_idx(REG_ADDR, OFS_REDIR_CFG)]);
    else if (in_table(REG_ADDR, OFS_LEARN_CFG, NUM_PORTS))
      rdata_next = DATA_W'(learn_cfg_reg[tbl_idx(REG_ADDR, OFS_LEARN_CFG)]);
    else if (in_table(REG_ADDR, OFS_RSV_QUEUE, RSV_COUNT))
      rdata_next = DATA_W'(rsv_queue_reg[tbl_idx(REG_ADDR, OFS_RSV_QUEUE)]);
    else if (REG_ADDR == OFS_STATUS)
      rdata_next = DATA_W'({VERDICT_OUT.dropped, VERDICT_OUT.to_cpu, VERDICT_OUT.valid});
    else if (REG_ADDR == OFS_FWD_COUNT)
      rdata_next = fwd_count_reg;
    else if (REG_ADDR == OFS_CPU_COUNT)
      rdata_next = cpu_count_reg;
    else if (REG_ADDR == OFS_DROP_COUNT)
      rdata_next = drop_count_reg;
  end

  always_ff @(posedge CORE_CLK or negedge RESETN)
  begin
    if (!RESETN)
      REG_RDATA <= '0;
    else if (REG_RD)
      REG_RDATA <= rdata_next;
    else
      REG_RDATA <= '0;
  end

endmodule : pacf_filter
`default_nettype wire

// *** pacf_pkg.sv ***
// package for the port access control forwarding filter
package pacf_pkg;
  localparam int unsigned NUM_PORTS      = 12;
  localparam int unsigned NUM_AGGR       = 16;
  localparam int unsigned AC_W           = 4;
  localparam int unsigned QUEUE_W        = 3;
  localparam int unsigned ADDR_W         = 8;
  localparam int unsigned DATA_W         = 32;
  localparam int unsigned PORT_IDX_W     = 4;
  localparam int unsigned RSV_IDX_W      = 4;
  localparam int unsigned RSV_COUNT      = 16;
  localparam logic [47:0] RSV_MAC_BASE   = 48'h0180_C200_0000;
  localparam logic [43:0] RSV_MAC_PREFIX = 44'h0180_C200_000;
  localparam logic [RSV_IDX_W-1:0] AUTH_RSV_IDX = 4'h3;

  // register word offsets (byte address = 4 * index)
  localparam logic [ADDR_W-1:0] OFS_AGGR_MASK   = 8'h00; // 16 words
  localparam logic [ADDR_W-1:0] OFS_SRC_MASK    = 8'h10; // 12 words
  localparam logic [ADDR_W-1:0] OFS_REDIR_CFG   = 8'h20; // 12 words
  localparam logic [ADDR_W-1:0] OFS_LEARN_CFG   = 8'h30; // 12 words
  localparam logic [ADDR_W-1:0] OFS_RSV_QUEUE   = 8'h40; // 16 words
  localparam logic [ADDR_W-1:0] OFS_STATUS      = 8'h50;
  localparam logic [ADDR_W-1:0] OFS_FWD_COUNT   = 8'h51;
  localparam logic [ADDR_W-1:0] OFS_CPU_COUNT   = 8'h52;
  localparam logic [ADDR_W-1:0] OFS_DROP_COUNT  = 8'h53;

  // learn cfg field positions
  localparam int unsigned LRN_ENA_BIT  = 0;
  localparam int unsigned LRN_CPU_BIT  = 1;
  localparam int unsigned LRN_DROP_BIT = 2;
  localparam int unsigned LRN_AUTO_BIT = 3;

  localparam logic [NUM_PORTS-1:0] SRC_MASK_RESET  = 12'hFFF;
  localparam logic [NUM_PORTS-1:0] AGGR_MASK_RESET = 12'hFFF;
  localparam logic [DATA_W-1:0]    UNMAPPED_DATA   = 32'h0000_0000;

  typedef struct packed {
    logic                  valid;
    logic [PORT_IDX_W-1:0] src_port;
    logic [47:0]           dmac;
    logic [NUM_PORTS-1:0]  dest_set;
    logic [AC_W-1:0]       aggr_code;
    logic                  smac_known;
  } pacf_frame_type;

  typedef struct packed {
    logic                  valid;
    logic [NUM_PORTS-1:0]  fwd_ports;
    logic                  to_cpu;
    logic [QUEUE_W-1:0]    cpu_queue;
    logic                  learn_req;
    logic                  dropped;
  } pacf_verdict_type;
endpackage : pacf_pkg

// *** pacf_filter_chk.sv ***
// port assertions for the access control filter
`timescale 1ns/10ps
`default_nettype none
module pacf_filter_chk
  import pacf_pkg::*;
(
  input wire logic              CORE_CLK,
  input wire logic              RESETN,
  input wire logic [ADDR_W-1:0] REG_ADDR,
  input wire logic              REG_RD,
  input wire logic [DATA_W-1:0] REG_RDATA,
  input wire pacf_frame_type    FRAME_IN,
  input wire pacf_verdict_type  VERDICT_OUT
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);
  sequence s_take;
    FRAME_IN.valid && (32'(FRAME_IN.src_port) < NUM_PORTS);
  endsequence
  property p_answer; s_take |=> VERDICT_OUT.valid; endproperty
  a_answer: assert property (p_answer) else $error("no verdict after frame");
  property p_quiet;
    !(FRAME_IN.valid && (32'(FRAME_IN.src_port) < NUM_PORTS)) |=> !VERDICT_OUT.valid;
  endproperty
  a_quiet: assert property (p_quiet) else $error("verdict without frame");
  property p_subset;
    VERDICT_OUT.valid |-> (VERDICT_OUT.fwd_ports & ~$past(FRAME_IN.dest_set)) == '0;
  endproperty
  a_subset: assert property (p_subset) else $error("port outside dest set");
  property p_drop; VERDICT_OUT.dropped |-> VERDICT_OUT.fwd_ports == '0 && !VERDICT_OUT.to_cpu; endproperty
  a_drop: assert property (p_drop) else $error("dropped frame still sent");
  property p_learn; VERDICT_OUT.learn_req |-> !$past(FRAME_IN.smac_known); endproperty
  a_learn: assert property (p_learn) else $error("learn request for known source");
  property p_redir;
    VERDICT_OUT.to_cpu && $past(FRAME_IN.smac_known) |-> VERDICT_OUT.fwd_ports == '0;
  endproperty
  a_redir: assert property (p_redir) else $error("redirected frame forwarded");
  property p_rd_idle; !$past(REG_RD) |-> REG_RDATA == '0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
  property p_unmapped; REG_RD && REG_ADDR > OFS_DROP_COUNT |=> REG_RDATA == '0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule : pacf_filter_chk
`default_nettype wire

// *** pacf_station.sv ***
// station model that puts frame descriptors on the ingress side
`timescale 1ns/10ps
`default_nettype none
module pacf_station
  import pacf_pkg::*;
(
  input  wire logic     clk,
  output var pacf_frame_type frame
);
  initial frame = '0;
  task automatic send(input logic [3:0] port, input logic [47:0] dmac,
                      input logic [11:0] dest, input logic [3:0] ac, input logic known);
    @(posedge clk);
    frame <= '{1'b1, port, dmac, dest, ac, known};
    @(posedge clk);
    // idle descriptor fields toggle so stale values are never trusted
    frame <= '{1'b0, ~port, ~dmac, ~dest, ~ac, ~known};
  endtask : send
endmodule : pacf_station
`default_nettype wire

// *** tb_pacf_filter.sv ***
// self-checking bench for the access control filter
`timescale 1ns/10ps
`default_nettype none
module tb_pacf_filter
  import pacf_pkg::*;
;
  localparam logic [47:0] AUTH_MAC = 48'h0180_C200_0003;
  logic              clk;
  logic              resetn;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              wr_s;
  logic              rd_s;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] rv;
  pacf_frame_type    frame;
  pacf_verdict_type  vd;
  int                n_errors = 0;
  int                samples_checked = 0;
  int                cycles = 0;
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  pacf_filter dut_u (.CORE_CLK(clk), .RESETN(resetn), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr_s), .REG_RD(rd_s), .REG_RDATA(rdata), .FRAME_IN(frame), .VERDICT_OUT(vd));
  pacf_station st_u (.clk(clk), .frame(frame));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    rv = rdata;
  endtask : rd
  task automatic vchk(input logic [11:0] fwd, input logic cpu, input logic lrn, input logic drp);
    #1;
    check("verdict", 32'({vd.valid, vd.fwd_ports, vd.to_cpu, vd.learn_req, vd.dropped}),
          32'({1'b1, fwd, cpu, lrn, drp}));
  endtask : vchk
  task automatic summarize();
    if (n_errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      n_errors++;
      summarize();
    end
  end
  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    resetn = 1'b0;
    addr = '0;
    wdata = '0;
    wr_s = 1'b0;
    rd_s = 1'b0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    rd(OFS_SRC_MASK);
    check("src mask reset", rv, 32'h0000_0FFF);
    rd(OFS_AGGR_MASK + 8'h0F);
    check("aggr mask reset", rv, 32'h0000_0FFF);
    rd(8'hFF);
    check("unmapped", rv, 32'h0000_0000);
    for (int i = 0; i < 16; i++) wr(OFS_AGGR_MASK + 8'(i), 32'h0000_0FF7);
    wr(OFS_SRC_MASK, 32'h0000_0000);
    wr(OFS_REDIR_CFG, 32'h0000_0008);
    wr(OFS_RSV_QUEUE + 8'h03, 32'h0000_0005);
    st_u.send(4'h0, AUTH_MAC, 12'hFFF, 4'h0, 1'b1);
    vchk(12'h000, 1'b1, 1'b0, 1'b0);
    check("queue", 32'(vd.cpu_queue), 32'h0000_0005);
    st_u.send(4'h0, 48'h0200_0000_0001, 12'hFFF, 4'h0, 1'b1);
    vchk(12'h000, 1'b0, 1'b0, 1'b1);
    st_u.send(4'h1, 48'h0200_0000_0001, 12'hFFF, 4'h7, 1'b1);
    vchk(12'hFF7, 1'b0, 1'b0, 1'b0);
    wr(OFS_SRC_MASK + 8'h01, 32'h0000_003C);
    st_u.send(4'h1, 48'h0200_0000_0001, 12'h0FE, 4'h2, 1'b1);
    vchk(12'h034, 1'b0, 1'b0, 1'b0);
    wr(OFS_LEARN_CFG + 8'h02, 32'h0000_0007);
    st_u.send(4'h2, 48'h0200_0000_0001, 12'hFFF, 4'h0, 1'b0);
    vchk(12'h000, 1'b1, 1'b1, 1'b0);
    check("queue", 32'(vd.cpu_queue), 32'h0000_0005);
    st_u.send(4'h2, 48'h0200_0000_0001, 12'hFFF, 4'h0, 1'b1);
    vchk(12'hFF7, 1'b0, 1'b0, 1'b0);
    wr(OFS_LEARN_CFG + 8'h02, 32'h0000_0005);
    st_u.send(4'h2, 48'h0200_0000_0001, 12'hFFF, 4'h0, 1'b0);
    vchk(12'h000, 1'b0, 1'b0, 1'b1);
    wr(OFS_REDIR_CFG + 8'h02, 32'h0000_0008);
    fork
      begin
        st_u.send(4'h2, AUTH_MAC, 12'hFFF, 4'h0, 1'b0);
        vchk(12'h000, 1'b1, 1'b0, 1'b0);
      end
      begin
        @(posedge clk);
        rd(OFS_STATUS);
      end
    join
    check("status", rv, 32'h0000_0003);
    for (int i = 0; i < 16; i++) wr(OFS_AGGR_MASK + 8'(i), 32'h0000_0FFF);
    wr(OFS_SRC_MASK, 32'h0000_0FFE);
    st_u.send(4'h0, 48'h0200_0000_0001, 12'h008, 4'h9, 1'b1);
    vchk(12'h008, 1'b0, 1'b0, 1'b0);
    wr(OFS_LEARN_CFG + 8'h03, 32'h0000_0009);
    st_u.send(4'h3, 48'h0200_0000_0001, 12'hFFF, 4'h0, 1'b0);
    vchk(12'hFFF, 1'b0, 1'b1, 1'b0);
    rd(OFS_LEARN_CFG + 8'h02);
    check("learn cfg", rv, 32'h0000_0005);
    rd(OFS_REDIR_CFG + 8'h02);
    check("redirect cfg", rv, 32'h0000_0008);
    rd(OFS_RSV_QUEUE + 8'h03);
    check("auth queue", rv, 32'h0000_0005);
    rd(OFS_FWD_COUNT);
    check("fwd count", rv, 32'h0000_0005);
    rd(OFS_CPU_COUNT);
    check("cpu count", rv, 32'h0000_0003);
    rd(OFS_DROP_COUNT);
    check("drop count", rv, 32'h0000_0002);
    summarize();
  end
endmodule : tb_pacf_filter
bind pacf_filter pacf_filter_chk chk_u (.CORE_CLK(CORE_CLK), .RESETN(RESETN),
  .REG_ADDR(REG_ADDR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .FRAME_IN(FRAME_IN),
  .VERDICT_OUT(VERDICT_OUT));
`default_nettype wire
